// ==== core/arb_pkg.sv ====
// constants and types shared by the bus release and special state control
package arb_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [3:0] SAVE_CYCLES = 4'h4;
  localparam logic [3:0] RESTORE_CYCLES = 4'h4;
  localparam logic [3:0] DRAIN_CYCLES = 4'h3;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  typedef enum logic [2:0] {
    CORE_RUN,
    CORE_SAVE,
    CORE_MGMT,
    CORE_RESTORE,
    CORE_DRAIN,
    CORE_GRANT,
    CORE_STOPPED
  } core_state_e;

  typedef enum logic [1:0] {
    BUS_OWNED,
    BUS_HOLD,
    BUS_BACKOFF
  } bus_state_e;
endpackage

// ==== core/bus_hold_smm_stopclock_ctrl.sv ====
// bus release, management mode and stop clock control of the processor
`timescale 1ns/1ps
module bus_hold_smm_stopclock_ctrl
  import arb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sys_mgmt_irq_n,
  input wire logic stop_clock_req_n,
  input wire logic bus_hold_request,
  input wire logic backoff_n,
  input wire logic non_burst_ready_n,
  input wire logic burst_ready_n,
  input wire logic core_bus_req,
  input wire logic cycle_active,
  input wire logic cycle_last,
  input wire logic locked_seq,
  input wire logic instr_boundary,
  input wire logic string_iter,
  input wire logic resume_exec,
  input wire logic higher_irq,
  output logic internal_bus_request,
  output logic hold_acknowledge,
  output logic bus_float,
  output logic cycle_restart,
  output logic cycle_done,
  output logic sys_mgmt_active_n,
  output logic sys_mgmt_mode,
  output logic core_halted,
  output logic stop_grant_cycle
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic smi_s;
  logic stop_clock_req_n_s;
  logic hold_s;
  logic backoff_n_s;

  pin_sync #(.RESET_VAL(1'b1)) u_smi (
    .core_clk(core_clk), .rst_n(rst_n), .pin_in(sys_mgmt_irq_n), .pin_sync_out(smi_s));
  pin_sync #(.RESET_VAL(1'b1)) u_stp (
    .core_clk(core_clk), .rst_n(rst_n), .pin_in(stop_clock_req_n), .pin_sync_out(stop_clock_req_n_s));
  pin_sync #(.RESET_VAL(1'b0)) u_hold (
    .core_clk(core_clk), .rst_n(rst_n), .pin_in(bus_hold_request), .pin_sync_out(hold_s));
  pin_sync #(.RESET_VAL(1'b1)) u_backoff_n (
    .core_clk(core_clk), .rst_n(rst_n), .pin_in(backoff_n), .pin_sync_out(backoff_n_s));

  // ---------------------------------------------------------------
  // bus ownership: hold and backoff
  // ---------------------------------------------------------------
  bus_state_e bus_q, bus_d;
  logic in_seq_q, in_seq_d;
  logic hold_acknowledge_q, hold_acknowledge_d;
  logic float_q, float_d;
  logic restart_q, restart_d;
  logic done_q, done_d;
  logic internal_bus_request_q, internal_bus_request_d;
  logic ready_seen;
  logic seq_end;

  // backoff masks ready, so a cycle cut short never completes
  assign ready_seen = backoff_n_s && (!non_burst_ready_n || !burst_ready_n);
  // a locked sequence counts as one unit for hold
  assign seq_end = cycle_active && cycle_last && ready_seen && !locked_seq;

  always_comb begin
    bus_d = bus_q;
    in_seq_d = in_seq_q;
    restart_d = 1'b0;
    done_d = 1'b0;
    internal_bus_request_d = core_bus_req;
    if (cycle_active && cycle_last && ready_seen) begin
      done_d = 1'b1;
    end
    if (cycle_active && !seq_end) begin
      in_seq_d = 1'b1;
    end else if (seq_end) begin
      in_seq_d = 1'b0;
    end
    case (bus_q)
      BUS_OWNED: begin
        if (!backoff_n_s) begin
          bus_d = BUS_BACKOFF;
        // grant on the closing ready itself, so back-to-back cycles cannot starve hold
        end else if (hold_s && (seq_end || (!in_seq_q && !cycle_active))) begin
          bus_d = BUS_HOLD;
        end
      end
      BUS_HOLD: begin
        if (!backoff_n_s) begin
          bus_d = BUS_BACKOFF;
        end else if (!hold_s) begin
          bus_d = BUS_OWNED;
        end
      end
      BUS_BACKOFF: begin
        if (backoff_n_s) begin
          bus_d = BUS_OWNED;
          restart_d = in_seq_q;
          in_seq_d = 1'b0;
        end
      end
      default: bus_d = BUS_OWNED;
    endcase
    hold_acknowledge_d = (bus_d == BUS_HOLD);
    float_d = (bus_d != BUS_OWNED);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bus_q <= BUS_OWNED;
      in_seq_q <= 1'b0;
      hold_acknowledge_q <= 1'b0;
      float_q <= 1'b0;
      restart_q <= 1'b0;
      done_q <= 1'b0;
      internal_bus_request_q <= 1'b0;
    end else begin
      bus_q <= bus_d;
      in_seq_q <= in_seq_d;
      hold_acknowledge_q <= hold_acknowledge_d;
      float_q <= float_d;
      restart_q <= restart_d;
      done_q <= done_d;
      internal_bus_request_q <= internal_bus_request_d;
    end
  end

  assign internal_bus_request = internal_bus_request_q;
  assign hold_acknowledge = hold_acknowledge_q;
  assign bus_float = float_q;
  assign cycle_restart = restart_q;
  assign cycle_done = done_q;

  // ---------------------------------------------------------------
  // management mode and stop clock sequencing
  // ---------------------------------------------------------------
  core_state_e core_q, core_d;
  logic smi_prev_q, smi_prev_d;
  logic smi_pend_q, smi_pend_d;
  logic [3:0] cnt_q, cnt_d;
  logic active_n_q, active_n_d;
  logic mode_q, mode_d;
  logic halted_q, halted_d;
  logic grant_q, grant_d;
  logic take_point;
  logic smi_fall;

  assign smi_fall = smi_prev_q && !smi_s;
  // boundary or string iteration, outside any locked sequence
  assign take_point = (instr_boundary || string_iter) && !locked_seq;

  always_comb begin
    core_d = core_q;
    smi_prev_d = smi_s;
    smi_pend_d = smi_pend_q || smi_fall; // set wins; only one edge held
    cnt_d = (cnt_q != CNT_ZERO) ? cnt_q - 4'h1 : CNT_ZERO;
    grant_d = 1'b0;
    case (core_q)
      CORE_RUN: begin
        if (take_point && smi_pend_q) begin
          core_d = CORE_SAVE;
          smi_pend_d = smi_fall;
          cnt_d = SAVE_CYCLES;
        end else if (take_point && !stop_clock_req_n_s && !higher_irq) begin
          core_d = CORE_DRAIN;
          cnt_d = DRAIN_CYCLES;
        end
      end
      CORE_SAVE: begin
        if (cnt_q == CNT_ZERO) begin
          core_d = CORE_MGMT;
        end
      end
      CORE_MGMT: begin
        // handler runs uninterrupted; pending edge waits for resume
        if (resume_exec) begin
          core_d = CORE_RESTORE;
          cnt_d = RESTORE_CYCLES;
        end
      end
      CORE_RESTORE: begin
        if (cnt_q == CNT_ZERO) begin
          core_d = CORE_RUN;
        end
      end
      CORE_DRAIN: begin
        // grant is a bus cycle, so wait for ownership
        if (cnt_q == CNT_ZERO && bus_q == BUS_OWNED) begin
          core_d = CORE_GRANT;
          grant_d = 1'b1;
        end
      end
      CORE_GRANT: core_d = CORE_STOPPED;
      CORE_STOPPED: begin
        if (stop_clock_req_n_s) begin
          core_d = CORE_RUN;
        end
      end
      default: core_d = CORE_RUN;
    endcase
    active_n_d = !(core_d == CORE_SAVE || core_d == CORE_MGMT
      || core_d == CORE_RESTORE);
    mode_d = !active_n_d;
    halted_d = (core_d == CORE_GRANT || core_d == CORE_STOPPED);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      core_q <= CORE_RUN;
      smi_prev_q <= 1'b1;
      smi_pend_q <= 1'b0;
      cnt_q <= CNT_ZERO;
      active_n_q <= 1'b1;
      mode_q <= 1'b0;
      halted_q <= 1'b0;
      grant_q <= 1'b0;
    end else begin
      core_q <= core_d;
      smi_prev_q <= smi_prev_d;
      smi_pend_q <= smi_pend_d;
      cnt_q <= cnt_d;
      active_n_q <= active_n_d;
      mode_q <= mode_d;
      halted_q <= halted_d;
      grant_q <= grant_d;
    end
  end

  assign sys_mgmt_active_n = active_n_q;
  assign sys_mgmt_mode = mode_q;
  assign core_halted = halted_q;
  assign stop_grant_cycle = grant_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence backoff_n_low_s;
    !backoff_n_s;
  endsequence

  a_ack_matches_float: assert property (@(posedge core_clk) disable iff (!rst_n)
    hold_acknowledge |-> bus_float) else $error("ack without float");
  a_backoff_floats: assert property (@(posedge core_clk) disable iff (!rst_n)
    backoff_n_low_s |=> bus_float && !hold_acknowledge) else $error("backoff did not float");
  a_hold_stays: assert property (@(posedge core_clk) disable iff (!rst_n)
    hold_acknowledge && hold_s && backoff_n_s |=> hold_acknowledge) else $error("hold dropped");
  a_hold_waits_seq: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(hold_acknowledge) |-> !in_seq_q && !($past(cycle_active) && $past(locked_seq)))
    else $error("hold split sequence");
  a_internal_bus_request_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
    core_bus_req |=> internal_bus_request) else $error("request not shown");
  a_ready_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
    !backoff_n_s |=> !cycle_done) else $error("ready taken under backoff");
  a_restart_after: assert property (@(posedge core_clk) disable iff (!rst_n)
    cycle_restart |-> $past(bus_q) == BUS_BACKOFF) else $error("bad restart");
  a_active_span: assert property (@(posedge core_clk) disable iff (!rst_n)
    !sys_mgmt_active_n && !$past(sys_mgmt_active_n) |-> sys_mgmt_mode)
    else $error("active without mode");
  a_no_nest: assert property (@(posedge core_clk) disable iff (!rst_n)
    core_q == CORE_MGMT && !resume_exec |=> core_q == CORE_MGMT) else $error("handler broken");
  a_grant_once: assert property (@(posedge core_clk) disable iff (!rst_n)
    stop_grant_cycle |=> !stop_grant_cycle ##0 core_halted) else $error("grant not single");
endmodule

// ==== core/pin_sync.sv ====
// two flip-flop synchroniser for one asynchronous pin
`timescale 1ns/1ps
module pin_sync
  import arb_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic pin_sync_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // first stage only feeds the second
  always_comb begin
    meta_d = pin_in;
    sync_d = meta_q;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign pin_sync_out = sync_q;
endmodule

// ==== sim/arb_model.sv ====
// far side model: bus master, arbiter and stop clock requester
`timescale 1ns/1ps
module arb_model (
  input wire logic core_clk,
  input wire logic want_hold,
  input wire logic want_backoff_n,
  input wire logic want_stop,
  input wire logic stop_grant_cycle,
  output logic bus_hold_request,
  output logic backoff_n,
  output logic stop_clock_req_n
);
  logic granted_q = 1'b0;
  initial begin
    bus_hold_request = 1'b0;
    backoff_n = 1'b1;
    stop_clock_req_n = 1'b1;
  end
  // ----------------------------------------
  // pins move on the falling edge only
  // ----------------------------------------
  always @(negedge core_clk) begin
    bus_hold_request <= want_hold;
    backoff_n <= ~want_backoff_n;
    if (stop_grant_cycle)
      granted_q <= 1'b1;
    else if (!want_stop)
      granted_q <= 1'b0;
    // low until grant seen, then let go at once to test early release
    stop_clock_req_n <= ~(want_stop & ~granted_q & ~stop_grant_cycle);
  end
endmodule

// ==== sim/tb_bus_hold_smm_stopclock_ctrl.sv ====
// self-checking bench for bus release, management mode and stop clock
`timescale 1ns/1ps
module tb_bus_hold_smm_stopclock_ctrl;
  import arb_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic irq_n = 1'b1, nb_rdy_n = 1'b1, b_rdy_n = 1'b1, core_req = 1'b0;
  logic cyc = 1'b0, cyc_last = 1'b0, locked = 1'b0, bound = 1'b0;
  logic iter = 1'b0, resume = 1'b0, hi_irq = 1'b0;
  logic want_hold = 1'b0, want_backoff_n = 1'b0, want_stop = 1'b0;
  logic hold_req, backoff_n_n, stop_n;
  logic ibr, ack, flt, restart, done, act_n, mode, halted, grant;
  int err_count = 0;
  int tests_run = 0;

  always #12.5 core_clk = ~core_clk;

  bus_hold_smm_stopclock_ctrl dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .sys_mgmt_irq_n(irq_n),
    .stop_clock_req_n(stop_n), .bus_hold_request(hold_req), .backoff_n(backoff_n_n),
    .non_burst_ready_n(nb_rdy_n), .burst_ready_n(b_rdy_n), .core_bus_req(core_req),
    .cycle_active(cyc), .cycle_last(cyc_last), .locked_seq(locked),
    .instr_boundary(bound), .string_iter(iter), .resume_exec(resume),
    .higher_irq(hi_irq), .internal_bus_request(ibr), .hold_acknowledge(ack),
    .bus_float(flt), .cycle_restart(restart), .cycle_done(done),
    .sys_mgmt_active_n(act_n), .sys_mgmt_mode(mode), .core_halted(halted),
    .stop_grant_cycle(grant));

  arb_model model_u (
    .core_clk(core_clk), .want_hold(want_hold), .want_backoff_n(want_backoff_n),
    .want_stop(want_stop), .stop_grant_cycle(grant), .bus_hold_request(hold_req),
    .backoff_n(backoff_n_n), .stop_clock_req_n(stop_n));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    if (err_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return ack;
      1: return flt;
      2: return act_n;
      3: return grant;
      4: return restart;
      5: return halted;
      default: return done;
    endcase
  endfunction

  // bounded wait; running out ends the run as a mismatch
  task automatic wait_for(input int w, input logic v, input int lim);
    int n;
    n = 0;
    tests_run++;
    while (pick(w) !== v) begin
      @(negedge core_clk);
      n++;
      if (n > lim) begin
        chk(pick(w), v);
        tally_and_finish();
      end
    end
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // one cycle pulse on boundary, iteration point or resume
  task automatic strobe(input int w);
    {resume, iter, bound} = 3'h1 << w;
    cyc_n(1);
    {resume, iter, bound} = 3'h0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_hold();
    cyc = 1'b1;
    core_req = 1'b1;
    want_hold = 1'b1;
    cyc_n(6);
    chk({ack, flt}, 2'h0);
    // the running cycle must end with ready before the bus is given away
    {cyc_last, nb_rdy_n} = 2'h2;
    cyc_n(1);
    chk(done, 1'b1);
    {cyc, cyc_last, nb_rdy_n} = 3'h1;
    wait_for(0, 1'b1, 4);
    chk(flt, 1'b1);
    cyc_n(8);
    chk({ack, flt, ibr}, 3'h7);
    // backoff during hold takes over the float and drops the acknowledge
    want_backoff_n = 1'b1;
    wait_for(0, 1'b0, 5);
    chk(flt, 1'b1);
    want_backoff_n = 1'b0;
    wait_for(0, 1'b1, 6);
    want_hold = 1'b0;
    core_req = 1'b0;
    wait_for(0, 1'b0, 4);
    cyc_n(2);
    chk({flt, ibr}, 2'h0);
  endtask

  task automatic t_backoff_n();
    cyc = 1'b1;
    cyc_last = 1'b1;
    want_backoff_n = 1'b1;
    wait_for(1, 1'b1, 5);
    {nb_rdy_n, b_rdy_n} = 2'h0;
    cyc_n(2);
    chk({done, ack}, 2'h0);
    {nb_rdy_n, b_rdy_n} = 2'h3;
    want_backoff_n = 1'b0;
    wait_for(4, 1'b1, 6);
    wait_for(1, 1'b0, 2);
    nb_rdy_n = 1'b0;
    wait_for(6, 1'b1, 3);
    nb_rdy_n = 1'b1;
    cyc = 1'b0;
    cyc_last = 1'b0;
  endtask

  task automatic t_smi();
    locked = 1'b1;
    irq_n = 1'b0;
    cyc_n(4);
    strobe(0);
    cyc_n(3);
    chk(act_n, 1'b1);
    locked = 1'b0;
    strobe(0);
    wait_for(2, 1'b0, 3);
    chk(mode, 1'b1);
    irq_n = 1'b1;
    cyc_n(2);
    irq_n = 1'b0;
    cyc_n(4);
    strobe(0);
    strobe(2);
    cyc_n(3);
    chk(act_n, 1'b0);
    wait_for(2, 1'b1, 4);
    irq_n = 1'b1;
    strobe(1);
    wait_for(2, 1'b0, 3);
    cyc_n(6);
    strobe(2);
    wait_for(2, 1'b1, 8);
  endtask

  task automatic t_stop();
    want_stop = 1'b1;
    hi_irq = 1'b1;
    cyc_n(4);
    strobe(0);
    cyc_n(8);
    chk(halted, 1'b0);
    hi_irq = 1'b0;
    strobe(0);
    wait_for(3, 1'b1, 12);
    cyc_n(1);
    chk(halted, 1'b1);
    wait_for(5, 1'b0, 6);
    want_stop = 1'b0;
  endtask

  initial begin
    cyc_n(6);
    chk({ibr, ack, flt, restart, done, act_n, mode, halted}, 8'h04);
    rst_n = 1'b1;
    cyc_n(3);
    t_hold();
    t_backoff_n();
    t_smi();
    t_stop();
    tally_and_finish();
  end
endmodule
